// ==== verilog/shub_pkg.sv ====
// Functional notes
// - Local memory is 640K bytes in independent 32 kB banks of 32-bit words.
// - Stored words carry ECC: single-bit errors corrected, double-bit errors detected.
// - Hub core and management agent share the memory through an arbiter.
// - Each bank has its own firmware-controlled power-gate; other banks keep working.
// - Memory holds code and serves run-time reads and writes.
// - Every type 0 configuration cycle from the host goes to config space.
// - First memory window exposes functional registers to the host driver.
// - Second memory window aliases config space, only while config space is hidden.
// - DMA addresses are up to 64 bits wide.
// - Host interrupts use a legacy interrupt line only, never message-signalled.
// - No power-management-event wake; capability reports no support.
// - Logic runs only in working and idle-standby states.
// - Local interrupt unit takes controller messages; boot ROM holds init firmware.
// - Four message-plus-interrupt flows: hub/host and hub/agent, both directions.
// - Shared status and remap registers, read/write from both sides, no interrupts.
package shub_pkg;
  localparam int unsigned WORD_BITS = 32;
  localparam int unsigned CHK_BITS = 7;
  localparam int unsigned CW_BITS = WORD_BITS + CHK_BITS;
  localparam int unsigned SYN_W = CHK_BITS - 1;
  localparam logic [SYN_W-1:0] SYN_LIMIT = 6'h27;
  localparam int unsigned BANK_BYTES = 32768;
  localparam int unsigned TOTAL_BYTES = 655360;
  localparam int unsigned NUM_BANKS = TOTAL_BYTES / BANK_BYTES;
  localparam int unsigned BANK_WORDS = BANK_BYTES / (WORD_BITS / 8);
  localparam int unsigned MEM_WORDS = NUM_BANKS * BANK_WORDS;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned BANK_LSB = 13;
  localparam int unsigned BANK_IDX_W = ADDR_W - BANK_LSB;
  localparam logic [BANK_IDX_W-1:0] LAST_BANK = 5'h13;
  localparam logic [WORD_BITS-1:0] GATED_READ_DATA = 32'h0000_0000;
  localparam int unsigned DMA_ADDR_W = 64;
  localparam logic CFG_TYPE0 = 1'b0;
  localparam int unsigned WIN_BITS = 12;
  localparam int unsigned NUM_FLOWS = 4;
  localparam int unsigned FLOW_HUB_TO_HOST = 0;
  localparam int unsigned FLOW_HOST_TO_HUB = 1;
  localparam int unsigned FLOW_HUB_TO_AGENT = 2;
  localparam int unsigned FLOW_AGENT_TO_HUB = 3;
  localparam int unsigned NUM_SCRATCH = 4;
  localparam int unsigned VEC_W = 8;
  localparam int unsigned ROM_WORDS = 16;
  localparam int unsigned ROM_ADDR_W = 4;
  localparam logic OWNER_CORE = 1'b0;
  localparam logic OWNER_AGENT = 1'b1;
  typedef enum logic [1:0] {MEM_IDLE, MEM_ACCESS, MEM_RESP} shub_mem_state_type;
  typedef enum logic [2:0] {PWR_WORKING, PWR_IDLE_STANDBY, PWR_SUSPEND, PWR_HIBERNATE,
                            PWR_SOFT_OFF} shub_pwr_type;
endpackage : shub_pkg

// ==== verilog/shub_ecc_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface shub_ecc_if;
  import shub_pkg::*;
  logic [WORD_BITS-1:0] enc_data;
  logic [CW_BITS-1:0] enc_cw;
  logic [CW_BITS-1:0] dec_cw;
  logic [WORD_BITS-1:0] dec_data;
  logic dec_single;
  logic dec_multi;
  modport codec (input enc_data, input dec_cw, output enc_cw, output dec_data,
                 output dec_single, output dec_multi);
  modport user (output enc_data, output dec_cw, input enc_cw, input dec_data,
                input dec_single, input dec_multi);
endinterface : shub_ecc_if
`default_nettype wire

// ==== verilog/shub_ecc.sv ====
`timescale 1ns/1ns
`default_nettype none
// Hamming SECDED: positions 1..38 hold the code, bit 0 the overall parity
module shub_ecc
  import shub_pkg::*;
(
  shub_ecc_if.codec ecc
);
  function automatic logic [CW_BITS-1:0] shub_encode(input logic [WORD_BITS-1:0] d);
    logic [CW_BITS-1:0] cw;
    int k;
    cw = '0;
    k = 0;
    for (int p = 1; p < CW_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[k];
        k++;
      end
    end
    for (int i = 0; i < SYN_W; i++) begin
      for (int p = 1; p < CW_BITS; p++) begin
        if (((p >> i) & 1) == 1 && p != (1 << i)) begin
          cw[1 << i] = cw[1 << i] ^ cw[p];
        end
      end
    end
    cw[0] = ^cw[CW_BITS-1:1];
    return cw;
  endfunction : shub_encode

  assign ecc.enc_cw = shub_encode(ecc.enc_data);

  always_comb begin
    logic [CW_BITS-1:0] fixed;
    logic [SYN_W-1:0] syn;
    logic par;
    int k;
    fixed = ecc.dec_cw;
    syn = '0;
    par = ^ecc.dec_cw;
    k = 0;
    ecc.dec_data = '0;
    for (int p = 1; p < CW_BITS; p++) begin
      if (ecc.dec_cw[p]) begin
        syn = syn ^ SYN_W'(p);
      end
    end
    // Odd parity with an in-range syndrome is one flipped bit; syndrome 0 hits bit 0
    ecc.dec_single = par && (syn < SYN_LIMIT);
    ecc.dec_multi = (!par && syn != '0) || (par && syn >= SYN_LIMIT);
    if (ecc.dec_single) begin
      fixed[syn] = ~fixed[syn];
    end
    for (int p = 1; p < CW_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        ecc.dec_data[k] = fixed[p];
        k++;
      end
    end
  end
endmodule : shub_ecc
`default_nettype wire

// ==== verilog/shub_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module shub_top
  import shub_pkg::*;
#(
  parameter logic [ROM_WORDS*WORD_BITS-1:0] BOOT_IMAGE = '0
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] pwr_state,
  input wire logic core_req,
  input wire logic core_we,
  input wire logic [ADDR_W-1:0] core_addr,
  input wire logic [WORD_BITS-1:0] core_wdata,
  output logic core_ack_ff,
  output logic [WORD_BITS-1:0] core_rdata_ff,
  input wire logic agent_req,
  input wire logic agent_we,
  input wire logic [ADDR_W-1:0] agent_addr,
  input wire logic [WORD_BITS-1:0] agent_wdata,
  output logic agent_ack_ff,
  output logic [WORD_BITS-1:0] agent_rdata_ff,
  input wire logic [NUM_BANKS-1:0] bank_sleep,
  input wire logic ecc_status_clr,
  output logic ecc_corr_pulse_ff,
  output logic ecc_uncorr_pulse_ff,
  output logic ecc_corr_sticky_ff,
  output logic ecc_uncorr_sticky_ff,
  output logic [ADDR_W-1:0] ecc_err_addr_ff,
  input wire logic cfg_valid,
  input wire logic cfg_type,
  output logic to_cfg_space_ff,
  output logic cfg_unsupported_ff,
  input wire logic mem_valid,
  input wire logic [DMA_ADDR_W-1:0] mem_addr,
  input wire logic [DMA_ADDR_W-1:0] function_register_window_base,
  input wire logic [DMA_ADDR_W-1:0] config_alias_window_base,
  input wire logic cfg_hidden,
  output logic to_func_regs_ff,
  output logic to_cfg_alias_ff,
  output logic mem_unclaimed_ff,
  output logic [WIN_BITS-1:0] win_offset_ff,
  input wire logic dma_valid,
  input wire logic [DMA_ADDR_W-1:0] dma_addr,
  output logic dma_out_valid_ff,
  output logic [DMA_ADDR_W-1:0] dma_out_addr_ff,
  output logic legacy_interrupt_line_ff,
  output logic pme_supported_ff,
  input wire logic [NUM_FLOWS-1:0] ipc_post,
  input wire logic [NUM_FLOWS-1:0][WORD_BITS-1:0] ipc_msg_in,
  input wire logic [NUM_FLOWS-1:0] ipc_done,
  output logic [NUM_FLOWS-1:0] ipc_busy_ff,
  output logic [NUM_FLOWS-1:0][WORD_BITS-1:0] ipc_msg_ff,
  input wire logic [NUM_SCRATCH-1:0] hub_scr_we,
  input wire logic [NUM_SCRATCH-1:0][WORD_BITS-1:0] hub_scr_wdata,
  input wire logic [NUM_SCRATCH-1:0] peer_scr_we,
  input wire logic [NUM_SCRATCH-1:0][WORD_BITS-1:0] peer_scr_wdata,
  output logic [NUM_SCRATCH-1:0][WORD_BITS-1:0] scratch_ff,
  input wire logic ioint_msg_valid,
  input wire logic [VEC_W-1:0] ioint_vector,
  input wire logic core_int_ack,
  output logic core_int_pending_ff,
  output logic [VEC_W-1:0] core_int_vector_ff,
  input wire logic rom_rd,
  input wire logic [ROM_ADDR_W-1:0] rom_addr,
  output logic [WORD_BITS-1:0] rom_data_ff
);
  logic run;
  // Inputs outside working/idle-standby are held low by the board, so freezing is safe
  assign run = ce && (pwr_state == PWR_WORKING || pwr_state == PWR_IDLE_STANDBY);

  shub_ecc_if ecc_bus ();
  shub_ecc u_ecc (.ecc(ecc_bus));

  // Memory: round-robin arbiter, one access in flight
  logic [CW_BITS-1:0] mem [MEM_WORDS];
  logic [CW_BITS-1:0] rd_cw_ff;
  shub_mem_state_type mst_ff, nxt_mst;
  logic own_ff, nxt_own, last_ff, nxt_last, we_ff, nxt_we, gated_ff, nxt_gated;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [WORD_BITS-1:0] wdata_ff, nxt_wdata;
  logic nxt_core_ack, nxt_agent_ack, nxt_corr_pulse, nxt_uncorr_pulse;
  logic nxt_corr_sticky, nxt_uncorr_sticky;
  logic [WORD_BITS-1:0] nxt_core_rdata, nxt_agent_rdata, rdata;
  logic [ADDR_W-1:0] nxt_err_addr;
  logic core_ok, agent_ok, pick;
  logic [BANK_IDX_W-1:0] bank_idx;

  assign ecc_bus.enc_data = wdata_ff;
  assign ecc_bus.dec_cw = rd_cw_ff;

  always_comb begin
    nxt_mst = mst_ff;
    nxt_own = own_ff;
    nxt_last = last_ff;
    nxt_we = we_ff;
    nxt_gated = gated_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_core_ack = 1'b0;
    nxt_agent_ack = 1'b0;
    nxt_core_rdata = core_rdata_ff;
    nxt_agent_rdata = agent_rdata_ff;
    nxt_corr_pulse = 1'b0;
    nxt_uncorr_pulse = 1'b0;
    nxt_corr_sticky = ecc_corr_sticky_ff && !ecc_status_clr;
    nxt_uncorr_sticky = ecc_uncorr_sticky_ff && !ecc_status_clr;
    nxt_err_addr = ecc_err_addr_ff;
    // A requester is not re-taken in the one cycle its ack is still high
    core_ok = core_req && !core_ack_ff;
    agent_ok = agent_req && !agent_ack_ff;
    pick = (core_ok && agent_ok) ? !last_ff : agent_ok;
    bank_idx = '0;
    rdata = gated_ff ? GATED_READ_DATA : ecc_bus.dec_data;
    case (mst_ff)
      MEM_IDLE: begin
        if (core_ok || agent_ok) begin
          nxt_own = pick;
          nxt_last = pick;
          nxt_addr = (pick == OWNER_AGENT) ? agent_addr : core_addr;
          nxt_we = (pick == OWNER_AGENT) ? agent_we : core_we;
          nxt_wdata = (pick == OWNER_AGENT) ? agent_wdata : core_wdata;
          bank_idx = nxt_addr[ADDR_W-1:BANK_LSB];
          // Out-of-range words behave like a gated bank
          nxt_gated = (bank_idx > LAST_BANK) || bank_sleep[bank_idx];
          nxt_mst = MEM_ACCESS;
        end
      end
      MEM_ACCESS: begin
        nxt_mst = MEM_RESP;
      end
      MEM_RESP: begin
        if (own_ff == OWNER_AGENT) begin
          nxt_agent_ack = 1'b1;
          nxt_agent_rdata = we_ff ? agent_rdata_ff : rdata;
        end else begin
          nxt_core_ack = 1'b1;
          nxt_core_rdata = we_ff ? core_rdata_ff : rdata;
        end
        if (!we_ff && !gated_ff) begin
          nxt_corr_pulse = ecc_bus.dec_single;
          nxt_uncorr_pulse = ecc_bus.dec_multi;
          // Set wins over a clear in the same cycle
          nxt_corr_sticky = nxt_corr_sticky || ecc_bus.dec_single;
          nxt_uncorr_sticky = nxt_uncorr_sticky || ecc_bus.dec_multi;
          if (ecc_bus.dec_single || ecc_bus.dec_multi) begin
            nxt_err_addr = addr_ff;
          end
        end
        nxt_mst = MEM_IDLE;
      end
      default: nxt_mst = MEM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mst_ff <= MEM_IDLE;
      own_ff <= OWNER_CORE;
      last_ff <= OWNER_AGENT;
      we_ff <= 1'b0;
      gated_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
      core_ack_ff <= 1'b0;
      agent_ack_ff <= 1'b0;
      core_rdata_ff <= '0;
      agent_rdata_ff <= '0;
      ecc_corr_pulse_ff <= 1'b0;
      ecc_uncorr_pulse_ff <= 1'b0;
      ecc_corr_sticky_ff <= 1'b0;
      ecc_uncorr_sticky_ff <= 1'b0;
      ecc_err_addr_ff <= '0;
    end else if (run) begin
      mst_ff <= nxt_mst;
      own_ff <= nxt_own;
      last_ff <= nxt_last;
      we_ff <= nxt_we;
      gated_ff <= nxt_gated;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      core_ack_ff <= nxt_core_ack;
      agent_ack_ff <= nxt_agent_ack;
      core_rdata_ff <= nxt_core_rdata;
      agent_rdata_ff <= nxt_agent_rdata;
      ecc_corr_pulse_ff <= nxt_corr_pulse;
      ecc_uncorr_pulse_ff <= nxt_uncorr_pulse;
      ecc_corr_sticky_ff <= nxt_corr_sticky;
      ecc_uncorr_sticky_ff <= nxt_uncorr_sticky;
      ecc_err_addr_ff <= nxt_err_addr;
    end
  end

  // Storage array; a gated bank neither writes nor is trusted on read
  always_ff @(posedge clk_sys) begin
    if (run && mst_ff == MEM_ACCESS) begin
      if (we_ff && !gated_ff) begin
        mem[addr_ff] <= ecc_bus.enc_cw;
      end
      rd_cw_ff <= gated_ff ? '0 : mem[addr_ff];
    end
  end

  // Host bridge, DMA address path, legacy interrupt
  logic nxt_to_cfg, nxt_cfg_unsup, nxt_to_func, nxt_to_alias, nxt_unclaimed;
  logic [WIN_BITS-1:0] nxt_win_offset;
  logic nxt_dma_valid, nxt_legacy, func_hit, alias_hit;
  logic [DMA_ADDR_W-1:0] nxt_dma_addr;

  always_comb begin
    func_hit = mem_addr[DMA_ADDR_W-1:WIN_BITS]
               == function_register_window_base[DMA_ADDR_W-1:WIN_BITS];
    alias_hit = cfg_hidden && (mem_addr[DMA_ADDR_W-1:WIN_BITS]
               == config_alias_window_base[DMA_ADDR_W-1:WIN_BITS]);
    nxt_to_cfg = cfg_valid && cfg_type == CFG_TYPE0;
    nxt_cfg_unsup = cfg_valid && cfg_type != CFG_TYPE0;
    nxt_to_func = mem_valid && func_hit;
    nxt_to_alias = mem_valid && !func_hit && alias_hit;
    nxt_unclaimed = mem_valid && !func_hit && !alias_hit;
    nxt_win_offset = mem_valid ? mem_addr[WIN_BITS-1:0] : win_offset_ff;
    nxt_dma_valid = dma_valid;
    nxt_dma_addr = dma_valid ? dma_addr : dma_out_addr_ff;
    // Hub-to-host doorbell is the only host interrupt and it goes out as a level
    nxt_legacy = ipc_busy_ff[FLOW_HUB_TO_HOST];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      to_cfg_space_ff <= 1'b0;
      cfg_unsupported_ff <= 1'b0;
      to_func_regs_ff <= 1'b0;
      to_cfg_alias_ff <= 1'b0;
      mem_unclaimed_ff <= 1'b0;
      win_offset_ff <= '0;
      dma_out_valid_ff <= 1'b0;
      dma_out_addr_ff <= '0;
      legacy_interrupt_line_ff <= 1'b0;
      pme_supported_ff <= 1'b0;
    end else if (run) begin
      to_cfg_space_ff <= nxt_to_cfg;
      cfg_unsupported_ff <= nxt_cfg_unsup;
      to_func_regs_ff <= nxt_to_func;
      to_cfg_alias_ff <= nxt_to_alias;
      mem_unclaimed_ff <= nxt_unclaimed;
      win_offset_ff <= nxt_win_offset;
      dma_out_valid_ff <= nxt_dma_valid;
      dma_out_addr_ff <= nxt_dma_addr;
      legacy_interrupt_line_ff <= nxt_legacy;
      pme_supported_ff <= 1'b0;
    end
  end

  // Message channels, shared scratch registers, local interrupt unit, boot ROM
  logic [NUM_FLOWS-1:0] nxt_busy;
  logic [NUM_FLOWS-1:0][WORD_BITS-1:0] nxt_msg;
  logic [NUM_SCRATCH-1:0][WORD_BITS-1:0] nxt_scratch;
  logic nxt_int_pending;
  logic [VEC_W-1:0] nxt_int_vector;
  logic [WORD_BITS-1:0] nxt_rom_data;

  always_comb begin
    nxt_busy = ipc_busy_ff;
    nxt_msg = ipc_msg_ff;
    for (int f = 0; f < NUM_FLOWS; f++) begin
      // A post to a busy channel is dropped, even in the cycle its done frees it
      if (ipc_done[f]) begin
        nxt_busy[f] = 1'b0;
      end
      if (ipc_post[f] && !ipc_busy_ff[f]) begin
        nxt_busy[f] = 1'b1;
        nxt_msg[f] = ipc_msg_in[f];
      end
    end
    nxt_scratch = scratch_ff;
    for (int s = 0; s < NUM_SCRATCH; s++) begin
      // Hub side wins a same-cycle collision; no interrupt is tied to these
      if (hub_scr_we[s]) begin
        nxt_scratch[s] = hub_scr_wdata[s];
      end else if (peer_scr_we[s]) begin
        nxt_scratch[s] = peer_scr_wdata[s];
      end
    end
    nxt_int_pending = core_int_pending_ff && !core_int_ack;
    nxt_int_vector = core_int_vector_ff;
    if (ioint_msg_valid && (!core_int_pending_ff || core_int_ack)) begin
      nxt_int_pending = 1'b1;
      nxt_int_vector = ioint_vector;
    end
    nxt_rom_data = rom_rd ? BOOT_IMAGE[rom_addr*WORD_BITS +: WORD_BITS] : rom_data_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ipc_busy_ff <= '0;
      ipc_msg_ff <= '0;
      scratch_ff <= '0;
      core_int_pending_ff <= 1'b0;
      core_int_vector_ff <= '0;
      rom_data_ff <= '0;
    end else if (run) begin
      ipc_busy_ff <= nxt_busy;
      ipc_msg_ff <= nxt_msg;
      scratch_ff <= nxt_scratch;
      core_int_pending_ff <= nxt_int_pending;
      core_int_vector_ff <= nxt_int_vector;
      rom_data_ff <= nxt_rom_data;
    end
  end
endmodule : shub_top
`default_nettype wire

// ==== test/shub_top_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module shub_chk
  import shub_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] pwr_state,
  input wire logic core_req,
  input wire logic core_ack_ff,
  input wire logic cfg_valid,
  input wire logic cfg_type,
  input wire logic to_cfg_space_ff,
  input wire logic cfg_unsupported_ff,
  input wire logic mem_valid,
  input wire logic [DMA_ADDR_W-1:0] mem_addr,
  input wire logic [DMA_ADDR_W-1:0] function_register_window_base,
  input wire logic cfg_hidden,
  input wire logic to_func_regs_ff,
  input wire logic to_cfg_alias_ff,
  input wire logic [WIN_BITS-1:0] win_offset_ff,
  input wire logic dma_valid,
  input wire logic [DMA_ADDR_W-1:0] dma_addr,
  input wire logic dma_out_valid_ff,
  input wire logic [DMA_ADDR_W-1:0] dma_out_addr_ff,
  input wire logic legacy_interrupt_line_ff,
  input wire logic pme_supported_ff,
  input wire logic [NUM_FLOWS-1:0] ipc_post,
  input wire logic [NUM_FLOWS-1:0][WORD_BITS-1:0] ipc_msg_in,
  input wire logic [NUM_FLOWS-1:0] ipc_busy_ff,
  input wire logic [NUM_FLOWS-1:0][WORD_BITS-1:0] ipc_msg_ff
);
  logic run;
  assign run = ce && (pwr_state < 3'h2);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_ack_single: assert property (core_ack_ff |=> !core_ack_ff)
    else $error("core ack too long");
  chk_core_answer: assert property ($rose(core_req) |->
    !core_ack_ff [*3] ##[1:4] core_ack_ff) else $error("core ack outside 3 to 6 cycles");
  chk_cfg_route: assert property (cfg_valid && run && cfg_type == CFG_TYPE0
    |=> to_cfg_space_ff && !cfg_unsupported_ff) else $error("type 0 cycle not routed");
  chk_alias_gate: assert property (to_cfg_alias_ff |->
    $past(cfg_hidden) && !to_func_regs_ff) else $error("alias hit while visible");
  chk_func_hit: assert property (mem_valid && run && mem_addr[DMA_ADDR_W-1:WIN_BITS] ==
    function_register_window_base[DMA_ADDR_W-1:WIN_BITS]
    |=> to_func_regs_ff && win_offset_ff == $past(mem_addr[WIN_BITS-1:0]))
    else $error("register window miss");
  chk_dma_pass: assert property (dma_valid && run
    |=> dma_out_valid_ff && dma_out_addr_ff == $past(dma_addr)) else $error("dma address lost");
  chk_legacy_line: assert property ($past(run) |-> legacy_interrupt_line_ff ==
    $past(ipc_busy_ff[FLOW_HUB_TO_HOST])) else $error("legacy line mismatch");
  chk_no_pme: assert property (!pme_supported_ff)
    else $error("wake capability reported");
  chk_ipc_take: assert property (ipc_post[1] && !ipc_busy_ff[1] && run
    |=> ipc_busy_ff[1] && ipc_msg_ff[1] == $past(ipc_msg_in[1])) else $error("post not taken");
  cov_alias: cover property (to_cfg_alias_ff);
  cov_standby: cover property (ipc_busy_ff[FLOW_AGENT_TO_HUB] && pwr_state == 3'h1);
  cov_frozen: cover property (!run ##1 run);
endmodule : shub_chk
bind shub_top shub_chk u_chk (.*);
`default_nettype wire

// ==== test/shub_agent_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Agent side of the shared memory; it only writes
module shub_agent_model
  import shub_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] lag,
  input wire logic [ADDR_W-1:0] go_addr,
  input wire logic [WORD_BITS-1:0] go_wdata,
  input wire logic agent_ack_ff,
  output logic agent_req,
  output logic agent_we,
  output logic [ADDR_W-1:0] agent_addr,
  output logic [WORD_BITS-1:0] agent_wdata,
  output logic agent_busy
);
  logic [4:0] cnt;
  logic [ADDR_W-1:0] addr_l;
  logic [WORD_BITS-1:0] data_l;
  assign agent_busy = agent_req || (cnt != 5'h00);
  always @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 5'h00;
      agent_req <= 1'b0;
      agent_we <= 1'b0;
      agent_addr <= '0;
      agent_wdata <= '0;
    end else if (go) begin
      cnt <= 5'(lag) + 5'h01;
      addr_l <= go_addr;
      data_l <= go_wdata;
    end else if (cnt == 5'h01) begin
      cnt <= 5'h00;
      agent_req <= 1'b1;
      agent_we <= 1'b1;
      agent_addr <= addr_l;
      agent_wdata <= data_l;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end else if (agent_req && agent_ack_ff) begin
      // Released lines flip so stale values never look live
      agent_req <= 1'b0;
      agent_we <= ~agent_we;
      agent_addr <= ~agent_addr;
      agent_wdata <= ~agent_wdata;
    end
  end
endmodule : shub_agent_model
`default_nettype wire

// ==== test/tb_sensor_hub_sram_bridge_ipc.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_sensor_hub_sram_bridge_ipc;
  import shub_pkg::*;
  localparam logic [ROM_WORDS*WORD_BITS-1:0] IMG = {16{32'h6b1d_e2a5}} + 512'h9c3;
  localparam logic [DMA_ADDR_W-1:0] FB = 64'h0000_0001_fed0_0000;
  localparam logic [DMA_ADDR_W-1:0] AB = 64'h0000_0001_fed4_0000;
  localparam logic [ADDR_W-1:0] ADRS [5] = '{18'h00000, 18'h01fff, 18'h02000,
    18'h26000, 18'h27fff};
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, go = 1'b0;
  logic [2:0] pwr_state = PWR_WORKING;
  logic core_req = 1'b0, core_we = 1'b0, agent_req, agent_we, agent_busy;
  logic [ADDR_W-1:0] core_addr = '0, agent_addr, ecc_err_addr_ff, go_addr = '0;
  logic [WORD_BITS-1:0] core_wdata = '0, agent_wdata, core_rdata_ff, agent_rdata_ff, rom_data_ff;
  logic core_ack_ff, agent_ack_ff, ecc_corr_pulse_ff, ecc_uncorr_pulse_ff, ecc_corr_sticky_ff;
  logic ecc_uncorr_sticky_ff, to_cfg_space_ff, cfg_unsupported_ff, to_func_regs_ff;
  logic to_cfg_alias_ff, mem_unclaimed_ff, dma_out_valid_ff, legacy_interrupt_line_ff;
  logic pme_supported_ff, core_int_pending_ff, cfg_valid = 1'b0, cfg_type = 1'b0;
  logic ecc_status_clr = 1'b0, mem_valid = 1'b0, cfg_hidden = 1'b0, dma_valid = 1'b0;
  logic ioint_msg_valid = 1'b0, core_int_ack = 1'b0, rom_rd = 1'b0;
  logic [NUM_BANKS-1:0] bank_sleep = '0;
  logic [DMA_ADDR_W-1:0] mem_addr = '0, dma_addr = '0, dma_out_addr_ff;
  logic [DMA_ADDR_W-1:0] function_register_window_base = FB, config_alias_window_base = AB;
  logic [WIN_BITS-1:0] win_offset_ff;
  logic [NUM_FLOWS-1:0] ipc_post = '0, ipc_done = '0, ipc_busy_ff, busy_q = '0;
  logic [NUM_FLOWS-1:0][WORD_BITS-1:0] ipc_msg_in = '0, ipc_msg_ff;
  logic [NUM_SCRATCH-1:0] hub_scr_we = '0, peer_scr_we = '0;
  logic [NUM_SCRATCH-1:0][WORD_BITS-1:0] hub_scr_wdata = '0, peer_scr_wdata = '0, scratch_ff;
  logic [VEC_W-1:0] ioint_vector = '0, core_int_vector_ff;
  logic [ROM_ADDR_W-1:0] rom_addr = '0;
  logic [3:0] lag = '0;
  logic [WORD_BITS-1:0] go_wdata = '0, rnd = 32'h0000_0039, d;
  logic [32:0] mq[$], ent;
  logic [4:0] bq[$], rt;
  logic [WORD_BITS-1:0] iq[$];
  int errors = 0, n_compared = 0, cyc = 0;
  shub_top #(.BOOT_IMAGE(IMG)) u_dut (.*);
  shub_agent_model u_agent (.*);
  initial forever #2 clk_sys = ~clk_sys;
  function logic [31:0] roll();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction : roll
  task chk_word(input string nm, input logic [63:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task chk_flag(input string nm, input logic e, g);
    chk_word(nm, 64'(e), 64'(g));
  endtask : chk_flag
  task wrap_up();
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task core_acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd, e);
    int n;
    @(posedge clk_sys);
    core_req <= 1'b1;
    core_we <= w;
    core_addr <= a;
    core_wdata <= wd;
    mq.push_back({~w, e});
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (core_ack_ff !== 1'b1 && n < 20);
    core_req <= 1'b0;
    core_we <= ~w;
    core_addr <= ~a;
    core_wdata <= ~wd;
  endtask : core_acc
  task route(input logic c, t, m, input logic [63:0] a, input logic [4:0] e);
    @(posedge clk_sys);
    cfg_valid <= c;
    cfg_type <= t;
    mem_valid <= m;
    mem_addr <= a;
    bq.push_back(e);
    @(posedge clk_sys);
    cfg_valid <= 1'b0;
    mem_valid <= 1'b0;
  endtask : route
  task ipc_flow(input int f, input logic [31:0] m);
    @(posedge clk_sys);
    ipc_post[f] <= 1'b1;
    ipc_msg_in[f] <= m;
    iq.push_back(m);
    @(posedge clk_sys);
    ipc_post[f] <= 1'b0;
    @(posedge clk_sys);
    ipc_post[f] <= 1'b1;
    ipc_msg_in[f] <= ~m;
    @(posedge clk_sys);
    ipc_post[f] <= 1'b0;
    @(posedge clk_sys);
    chk_word("ipc_msg", 64'(m), 64'(ipc_msg_ff[f]));
    chk_flag("legacy_line", f == FLOW_HUB_TO_HOST, legacy_interrupt_line_ff);
    ipc_done[f] <= 1'b1;
    @(posedge clk_sys);
    ipc_done[f] <= 1'b0;
    @(posedge clk_sys);
    chk_flag("ipc_busy", 1'b0, ipc_busy_ff[f]);
  endtask : ipc_flow
  always @(posedge clk_sys) begin
    if (core_ack_ff === 1'b1) begin
      ent = (mq.size() > 0) ? mq.pop_front() : 33'h1_dead_beef;
      if (ent[32]) chk_word("core_rdata", 64'(ent[31:0]), 64'(core_rdata_ff));
      chk_flag("ecc_flags", 1'b0, ecc_corr_pulse_ff | ecc_uncorr_pulse_ff);
    end
    rt = {to_cfg_space_ff, cfg_unsupported_ff, to_func_regs_ff, to_cfg_alias_ff,
          mem_unclaimed_ff};
    if (|rt === 1'b1) chk_word("route", 64'(bq.pop_front()), 64'(rt));
    for (int f = 0; f < NUM_FLOWS; f++)
      if (ipc_busy_ff[f] === 1'b1 && busy_q[f] !== 1'b1)
        chk_word("ipc_msg_up", 64'(iq.pop_front()), 64'(ipc_msg_ff[f]));
    busy_q <= ipc_busy_ff;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk_flag("pme_supported", 1'b0, pme_supported_ff);
    for (int i = 0; i < 5; i++) begin
      d = roll();
      core_acc(1'b1, ADRS[i], d, '0);
      core_acc(1'b0, ADRS[i], '0, d);
    end
    core_acc(1'b1, 18'h06004, 32'h0bad_f00d, '0);
    bank_sleep <= 20'h00004;
    core_acc(1'b1, 18'h04010, roll(), '0);
    core_acc(1'b0, 18'h04010, '0, GATED_READ_DATA);
    core_acc(1'b0, 18'h06004, '0, 32'h0bad_f00d);
    bank_sleep <= '0;
    // Agent lag 0 then 3, against a core write
    for (int k = 0; k < 2; k++) begin
      d = roll();
      @(posedge clk_sys);
      go <= 1'b1;
      lag <= 4'(3 * k);
      go_addr <= 18'h0e100 + 18'(k);
      go_wdata <= d;
      @(posedge clk_sys);
      go <= 1'b0;
      core_acc(1'b1, 18'h10200, roll(), '0);
      for (int n = 0; n < 40 && agent_busy !== 1'b0; n++) @(posedge clk_sys);
      core_acc(1'b0, 18'h0e100 + 18'(k), '0, d);
    end
    route(1'b1, CFG_TYPE0, 1'b0, '0, 5'b10000);
    route(1'b1, ~CFG_TYPE0, 1'b0, '0, 5'b01000);
    route(1'b0, 1'b0, 1'b1, FB + 64'h3a4, 5'b00100);
    route(1'b0, 1'b0, 1'b1, AB + 64'h010, 5'b00001);
    cfg_hidden <= 1'b1;
    route(1'b0, 1'b0, 1'b1, AB + 64'hffc, 5'b00010);
    route(1'b0, 1'b0, 1'b1, {roll(), roll()}, 5'b00001);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      dma_valid <= 1'b1;
      dma_addr <= {roll(), roll()};
    end
    @(posedge clk_sys);
    dma_valid <= 1'b0;
    for (int f = 0; f < NUM_FLOWS; f++) begin
      if (f == FLOW_AGENT_TO_HUB) pwr_state <= PWR_IDLE_STANDBY;
      ipc_flow(f, roll());
    end
    @(posedge clk_sys);
    hub_scr_we <= 4'h2;
    peer_scr_we <= 4'h6;
    hub_scr_wdata[1] <= 32'h1111_0001;
    peer_scr_wdata[1] <= 32'h2222_0001;
    peer_scr_wdata[2] <= 32'h2222_0002;
    ioint_msg_valid <= 1'b1;
    ioint_vector <= 8'h41;
    rom_rd <= 1'b1;
    rom_addr <= 4'h3;
    @(posedge clk_sys);
    hub_scr_we <= '0;
    peer_scr_we <= '0;
    ioint_vector <= 8'h7e;
    rom_rd <= 1'b0;
    @(posedge clk_sys);
    ioint_msg_valid <= 1'b0;
    chk_word("scratch1", 64'h1111_0001, 64'(scratch_ff[1]));
    chk_word("scratch2", 64'h2222_0002, 64'(scratch_ff[2]));
    chk_flag("no_irq", 1'b0, legacy_interrupt_line_ff | (|ipc_busy_ff));
    chk_word("rom", 64'(IMG[3*WORD_BITS +: WORD_BITS]), 64'(rom_data_ff));
    @(posedge clk_sys);
    chk_word("int_vector", 64'h41, 64'(core_int_vector_ff));
    core_int_ack <= 1'b1;
    @(posedge clk_sys);
    core_int_ack <= 1'b0;
    @(posedge clk_sys);
    chk_flag("int_pending", 1'b0, core_int_pending_ff);
    // Request and valid strobes stay low while suspended
    pwr_state <= PWR_SUSPEND;
    repeat (6) @(posedge clk_sys);
    pwr_state <= PWR_WORKING;
    ecc_status_clr <= 1'b1;
    @(posedge clk_sys);
    ecc_status_clr <= 1'b0;
    core_acc(1'b0, 18'h06004, '0, 32'h0bad_f00d);
    @(posedge clk_sys);
    chk_word("left", 64'h0, 64'(mq.size() + bq.size() + iq.size()));
    wrap_up();
  end
endmodule : tb_sensor_hub_sram_bridge_ipc
`default_nettype wire
